// *** src/rst_seq_pkg.sv ***
// constants for the chip reset sequencer, supply level monitor and watchdog
package rst_seq_pkg;
  // clock and timing, times in ns
  localparam int CLK_PERIOD_NS   = 20;
  localparam int RC_START_NS     = 13000;
  localparam int REG_SETTLE_NS   = 15000;
  localparam int BANDGAP_NS      = 150000;
  localparam int THR_PAUSE_NS    = 2500;
  // least times round up to whole cycles
  localparam int RC_START_CYC    = (RC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REG_SETTLE_CYC  = (REG_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BANDGAP_CYC     = (BANDGAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int THR_PAUSE_CYC   = (THR_PAUSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SEQ_CNT_W       = 13;
  // watchdog: shortest period 8 ms, doubled per prescale step up to 2^11
  localparam int WDT_BASE_US     = 8000;
  localparam int WDT_BASE_CYC    = WDT_BASE_US * 1000 / CLK_PERIOD_NS;
  localparam int WDT_CNT_W       = 30;
  localparam int WDT_SEL_W       = 4;
  localparam logic [3:0] WDT_SEL_MAX = 4'hB;
  // supply monitor threshold codes: 1.95 2.0 2.1 2.2 2.3 2.4 2.7 3.0 V
  localparam logic [2:0] THR_1V95 = 3'h0;
  localparam logic [2:0] THR_2V0  = 3'h1;
  localparam logic [2:0] THR_3V0  = 3'h7;
  // register offsets
  localparam logic [7:0] OFS_SYS_CTRL = 8'h00;
  localparam logic [7:0] OFS_WDT_CTRL = 8'h04;
  localparam logic [7:0] OFS_WDT_KICK = 8'h08;
  localparam logic [7:0] OFS_SVM_CTRL = 8'h0C;
  localparam logic [7:0] OFS_INT_STAT = 8'h10;
  localparam logic [7:0] OFS_INT_MASK = 8'h14;
  localparam logic [7:0] OFS_CAUSE    = 8'h18;
  localparam logic [7:0] OFS_WDT_CNT  = 8'h1C;
  // field positions
  localparam int SYS_SWRST_BIT  = 0;
  localparam int WDT_EN_BIT     = 0;
  localparam int WDT_SEL_LSB    = 1;
  localparam int WDT_EXC_BIT    = 5;
  localparam int SVM_THR_LSB    = 0;
  localparam int SVM_RMODE_BIT  = 3;
  localparam int SVM_EN_BIT     = 4;
  localparam int INT_FALL_BIT   = 0;
  localparam int INT_RISE_BIT   = 1;
  localparam int INT_WDT_BIT    = 2;
  localparam int CAUSE_POR_BIT  = 0;
  localparam int CAUSE_EXT_BIT  = 1;
  localparam int CAUSE_SW_BIT   = 2;
  localparam int CAUSE_WDT_BIT  = 3;
  localparam int CAUSE_SVM_BIT  = 4;
  // reset values
  localparam logic [2:0] INT_MASK_RST = 3'h0;
  localparam logic [4:0] CAUSE_RST    = 5'h01;
  // sequencer states
  typedef enum logic [2:0] {
    ST_HOLD, ST_RC_WAIT, ST_SUPPLY_CHK, ST_REG_SETTLE,
    ST_BANDGAP, ST_THR_PAUSE, ST_RECHECK, ST_RUN
  } seq_state_type;
endpackage

// *** src/reset_sequencer.sv ***
// chip reset sequencer with supply level monitor control and watchdog
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module reset_sequencer
  import rst_seq_pkg::*;
#(
  parameter int BANDGAP_CYCLES = BANDGAP_CYC,  // bandgap wait, shorten in sim
  parameter int WDT_BASE_CYCLES = WDT_BASE_CYC // shortest watchdog period
) (
  input  wire logic        clk_i,                    // 50 MHz clock
  input  wire logic        sys_rst_i,                // power-on reset, high
  input  wire logic        external_reset_pin_low_i, // reset pin level, low = reset
  input  wire logic        brownout_detector_i,      // brownout comparator, high = low vdd
  input  wire logic        supply_level_monitor_i,   // monitor comparator, high = above
  input  wire logic [2:0]  flash_thr_i,              // threshold setting from flash
  input  wire logic        sleep_i,                  // device in sleep
  input  wire logic        deep_sleep_i,             // device in deep sleep
  input  wire logic        dbg_stall_i,              // debugger stalls cpu
  input  wire logic [7:0]  addr_i,                   // register address
  input  wire logic [31:0] wdata_i,                  // write data
  input  wire logic        wr_i,                     // write strobe
  input  wire logic        rd_i,                     // read strobe
  output logic      [31:0] rdata_o,                  // read data, cycle after rd_i
  output logic             rc_osc_en_o,              // fast rc oscillator enable
  output logic             xtal_en_o,                // crystal oscillator enable
  output logic             regulator_en_o,           // core regulator enable
  output logic             cpu_rst_o,                // cpu and peripheral reset, high
  output logic      [2:0]  svm_thr_o,                // threshold code to comparator
  output logic             wdt_exc_o,                // watchdog exception pulse
  output logic             irq_o                     // level interrupt
);

  seq_state_type         state_r, state_nxt;
  logic [SEQ_CNT_W-1:0]  seq_cnt_r;
  logic [2:0]            sync1_r, sync2_r;
  logic                  supply_prev_r;
  logic                  sleep_prev_r;
  logic                  wdt_en_r, wdt_exc_mode_r;
  logic [WDT_SEL_W-1:0]  wdt_sel_r, wdt_act_sel_r;
  logic [WDT_CNT_W-1:0]  wdt_cnt_r;
  logic [2:0]            svm_thr_r;
  logic                  svm_rmode_r, svm_en_r;
  logic [2:0]            stat_r, mask_r;
  logic [4:0]            cause_r;
  logic [31:0]           rdata_r;
  logic                  irq_r, exc_r;
  logic                  rc_en_r, xtal_r, reg_en_r, cpu_rst_r;

  // two-stage synchroniser
  // bit0 pin level, bit1 monitor comparator, bit2 brownout
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync1_r <= 3'h4;
      sync2_r <= 3'h4;
    end else begin
      sync1_r <= {brownout_detector_i, supply_level_monitor_i, external_reset_pin_low_i};
      sync2_r <= sync1_r;
    end
  end

  wire pin_high_s   = sync2_r[0];
  wire supply_ok_s  = sync2_r[1];
  wire brownout_s   = sync2_r[2];

  // register decode
  wire wr_sys   = wr_i && (addr_i == OFS_SYS_CTRL);
  wire wr_wdt   = wr_i && (addr_i == OFS_WDT_CTRL);
  wire wr_kick  = wr_i && (addr_i == OFS_WDT_KICK);
  wire wr_svm   = wr_i && (addr_i == OFS_SVM_CTRL);
  wire wr_stat  = wr_i && (addr_i == OFS_INT_STAT);
  wire wr_mask  = wr_i && (addr_i == OFS_INT_MASK);
  wire wr_cause = wr_i && (addr_i == OFS_CAUSE);

  wire running   = (state_r == ST_RUN);
  wire in_hold   = (state_r == ST_HOLD);
  wire asleep    = sleep_i || deep_sleep_i;
  wire woke      = sleep_prev_r && !asleep;

  // software reset accepted in any state
  wire sw_req    = wr_sys && wdata_i[SYS_SWRST_BIT];

  // count only when enabled, running, awake and not stalled
  wire wdt_run    = running && wdt_en_r && !asleep && !dbg_stall_i;
  wire wdt_expire = wdt_run && (wdt_cnt_r == '0);
  // expiry gives chip reset unless exception mode chosen
  wire wdt_rst    = wdt_expire && !wdt_exc_mode_r;
  wire wdt_exc    = wdt_expire && wdt_exc_mode_r;

  // monitor acts only while running and awake
  wire svm_live  = running && svm_en_r && !asleep;
  wire svm_rst   = svm_live && svm_rmode_r && !supply_ok_s;
  wire svm_fall  = svm_live && !svm_rmode_r && supply_prev_r && !supply_ok_s;
  wire svm_rise  = svm_live && !svm_rmode_r && !supply_prev_r && supply_ok_s;

  wire ext_req   = !pin_high_s;
  wire chip_req  = brownout_s || ext_req || sw_req || wdt_rst || svm_rst;

  // reload value from the configured prescale wdt_sel_r, not the latched one
  wire [WDT_CNT_W-1:0] wdt_base   = WDT_CNT_W'(WDT_BASE_CYCLES - 1);
  wire [WDT_CNT_W-1:0] wdt_reload = WDT_CNT_W'((wdt_base + 1'b1) << wdt_sel_r) - 1'b1;

  // sequencer step length
  logic [SEQ_CNT_W-1:0] seq_last;
  always_comb begin
    unique case (state_r)
      ST_RC_WAIT:    seq_last = SEQ_CNT_W'(RC_START_CYC - 1);
      ST_REG_SETTLE: seq_last = SEQ_CNT_W'(REG_SETTLE_CYC - 1);
      ST_BANDGAP:    seq_last = SEQ_CNT_W'(BANDGAP_CYCLES - 1);
      ST_THR_PAUSE:  seq_last = SEQ_CNT_W'(THR_PAUSE_CYC - 1);
      default:       seq_last = '0;
    endcase
  end
  wire seq_done = (seq_cnt_r == seq_last);

  // sequencer next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      // stay while the pin is low or brownout stands
      ST_HOLD:       if (!brownout_s && !ext_req) state_nxt = ST_RC_WAIT;
      ST_RC_WAIT:    if (seq_done) state_nxt = ST_SUPPLY_CHK;
      // regulators wait for supply over default threshold
      ST_SUPPLY_CHK: if (supply_ok_s) state_nxt = ST_REG_SETTLE;
      ST_REG_SETTLE: if (seq_done) state_nxt = ST_BANDGAP;
      ST_BANDGAP:    if (seq_done) state_nxt = ST_THR_PAUSE;
      // pause after new threshold, then recheck
      ST_THR_PAUSE:  if (seq_done) state_nxt = ST_RECHECK;
      ST_RECHECK:    if (supply_ok_s) state_nxt = ST_RUN;
      ST_RUN:        state_nxt = ST_RUN;
    endcase
    // brownout and any other cause restart from hold
    if (chip_req) state_nxt = ST_HOLD;
  end

  // state and step counter; counter clears on every state change
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r   <= ST_HOLD;
      seq_cnt_r <= '0;
    end else begin
      state_r   <= state_nxt;
      seq_cnt_r <= (state_nxt != state_r) ? '0 : seq_cnt_r + 1'b1;
    end
  end

  // sequencer outputs, registered from the next state
  wire reg_on_nxt = (state_nxt != ST_HOLD) && (state_nxt != ST_RC_WAIT)
                    && (state_nxt != ST_SUPPLY_CHK);
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rc_en_r   <= 1'b0;
      xtal_r    <= 1'b0;
      reg_en_r  <= 1'b0;
      cpu_rst_r <= 1'b1;
    end else begin
      rc_en_r   <= (state_nxt != ST_HOLD);
      xtal_r    <= (state_nxt != ST_HOLD);
      reg_en_r  <= reg_on_nxt;
      cpu_rst_r <= (state_nxt != ST_RUN);
    end
  end

  // edge history for monitor crossings and wake detect
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      supply_prev_r <= 1'b0;
      sleep_prev_r  <= 1'b0;
    end else begin
      supply_prev_r <= supply_ok_s;
      sleep_prev_r  <= asleep;
    end
  end

  // watchdog configuration; chip reset and wake restore defaults
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wdt_en_r       <= 1'b1;
      wdt_sel_r      <= WDT_SEL_MAX;
      wdt_exc_mode_r <= 1'b0;
    end else if (in_hold || woke) begin
      wdt_en_r       <= 1'b1;
      wdt_sel_r      <= WDT_SEL_MAX;
      wdt_exc_mode_r <= 1'b0;
    end else if (wr_wdt) begin
      wdt_en_r       <= wdata_i[WDT_EN_BIT];
      wdt_sel_r      <= (wdata_i[WDT_SEL_LSB +: WDT_SEL_W] > WDT_SEL_MAX)
                        ? WDT_SEL_MAX : wdata_i[WDT_SEL_LSB +: WDT_SEL_W];
      wdt_exc_mode_r <= wdata_i[WDT_EXC_BIT];
    end
  end

  // down counter, period base times two to the prescale
  // kick reloads the full period and latches the prescale
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wdt_cnt_r     <= '1;
      wdt_act_sel_r <= WDT_SEL_MAX;
    end else if (in_hold || woke || wr_kick || wdt_exc) begin
      // counting starts as if just restarted
      wdt_cnt_r     <= (in_hold || woke) ? WDT_CNT_W'((wdt_base + 1'b1) << WDT_SEL_MAX) - 1'b1
                                         : wdt_reload;
      wdt_act_sel_r <= (in_hold || woke) ? WDT_SEL_MAX : wdt_sel_r;
    end else if (wdt_run) begin
      wdt_cnt_r     <= wdt_cnt_r - 1'b1;
    end
  end

  // supply monitor configuration
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      svm_thr_r   <= THR_2V0;
      svm_rmode_r <= 1'b1;
      svm_en_r    <= 1'b1;
    end else if (in_hold) begin
      // default threshold and monitor on until flash load
      svm_thr_r   <= THR_2V0;
      svm_rmode_r <= 1'b1;
      svm_en_r    <= 1'b1;
    end else if (state_r == ST_BANDGAP && seq_done) begin
      // user threshold taken from flash after bandgap wait
      svm_thr_r   <= flash_thr_i;
    end else if (wr_svm && running) begin
      svm_thr_r   <= wdata_i[SVM_THR_LSB +: 3];
      svm_rmode_r <= wdata_i[SVM_RMODE_BIT];
      svm_en_r    <= wdata_i[SVM_EN_BIT];
    end
  end

  // interrupt status, write one to clear; a new event wins over the clear
  wire [2:0] stat_set = {wdt_exc, svm_rise, svm_fall};
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stat_r <= '0;
      mask_r <= INT_MASK_RST;
    end else if (in_hold) begin
      stat_r <= '0;
      mask_r <= INT_MASK_RST;
    end else begin
      stat_r <= (stat_r & ~(wr_stat ? wdata_i[2:0] : 3'h0)) | stat_set;
      if (wr_mask) mask_r <= wdata_i[2:0];
    end
  end

  // cause flags survive chip reset; only power-on or a write of ones clears them
  wire [4:0] cause_set = (chip_req && !in_hold)
                         ? {svm_rst, wdt_rst, sw_req, ext_req, brownout_s} : 5'h00;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cause_r <= CAUSE_RST;
    end else begin
      cause_r <= (cause_r & ~(wr_cause ? wdata_i[4:0] : 5'h00)) | cause_set;
    end
  end

  // read mux
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    unique case (addr_i)
      OFS_WDT_CTRL: rd_mux = {26'h0, wdt_exc_mode_r, wdt_sel_r, wdt_en_r};
      OFS_SVM_CTRL: rd_mux = {27'h0, svm_en_r, svm_rmode_r, svm_thr_r};
      OFS_INT_STAT: rd_mux = {29'h0, stat_r};
      OFS_INT_MASK: rd_mux = {29'h0, mask_r};
      OFS_CAUSE:    rd_mux = {27'h0, cause_r};
      OFS_WDT_CNT:  rd_mux = {2'h0, wdt_cnt_r};
      default:      rd_mux = '0;
    endcase
  end

  // interrupt follows status and mask as they will stand next cycle
  wire [2:0] stat_nxt_view = in_hold ? 3'h0
                           : ((stat_r & ~(wr_stat ? wdata_i[2:0] : 3'h0)) | stat_set);
  wire [2:0] mask_nxt_view = in_hold ? INT_MASK_RST : (wr_mask ? wdata_i[2:0] : mask_r);

  // read data, interrupt and exception flops
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_r <= '0;
      irq_r   <= 1'b0;
      exc_r   <= 1'b0;
    end else begin
      rdata_r <= rd_i ? rd_mux : 32'h0;
      irq_r   <= |(stat_nxt_view & mask_nxt_view);
      exc_r   <= wdt_exc;
    end
  end

  assign rdata_o        = rdata_r;
  assign rc_osc_en_o    = rc_en_r;
  assign xtal_en_o      = xtal_r;
  assign regulator_en_o = reg_en_r;
  assign cpu_rst_o      = cpu_rst_r;
  assign svm_thr_o      = svm_thr_r;
  assign wdt_exc_o      = exc_r;
  assign irq_o          = irq_r;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_rc_end;
    state_r == ST_RC_WAIT && seq_cnt_r == SEQ_CNT_W'(RC_START_CYC - 1) && !chip_req;
  endsequence
  sequence s_recheck_ok;
    state_r == ST_RECHECK && supply_ok_s && !chip_req;
  endsequence

  a_rc_wait_len: assert property (s_rc_end |=> state_r == ST_SUPPLY_CHK)
    else $error("rc wait did not end on time");
  a_reg_gate: assert property ($rose(regulator_en_o) |-> $past(supply_ok_s))
    else $error("regulators on without supply");
  a_cpu_release: assert property (s_recheck_ok |=> !cpu_rst_o)
    else $error("cpu not released after recheck");
  a_cpu_hold_low: assert property ($fell(cpu_rst_o) |-> $past(state_r == ST_RECHECK))
    else $error("cpu released outside recheck");
  a_pin_hold: assert property (!pin_high_s |=> state_r == ST_HOLD ##1 cpu_rst_o)
    else $error("pin low did not hold reset");
  a_sw_reset: assert property (sw_req |=> state_r == ST_HOLD && cause_r[CAUSE_SW_BIT])
    else $error("software reset lost");
  a_wdt_reset: assert property (wdt_rst |=> state_r == ST_HOLD && cause_r[CAUSE_WDT_BIT])
    else $error("watchdog expiry did not reset");
  a_wdt_exc: assert property (wdt_exc |=> state_r == ST_RUN && wdt_exc_o)
    else $error("watchdog exception missing");
  a_wdt_pause: assert property (running && asleep && !in_hold |=> $stable(wdt_cnt_r))
    else $error("watchdog counted in sleep");
  a_wdt_default: assert property (in_hold |=> wdt_en_r && wdt_sel_r == WDT_SEL_MAX)
    else $error("watchdog default lost");
  a_irq_level: assert property (|(stat_r & mask_r) |-> irq_o)
    else $error("interrupt not raised");

  // watchdog pause, reload and wake defaults; flash load; monitor and brownout resets
  a_stall_pause: assert property (dbg_stall_i && !in_hold && !woke && !wr_kick
    |=> $stable(wdt_cnt_r))
    else $error("watchdog counted while stalled");
  a_kick_reload: assert property (wr_kick && !in_hold && !woke
    |=> wdt_cnt_r == WDT_CNT_W'((WDT_BASE_CYCLES << $past(wdt_sel_r)) - 1))
    else $error("kick did not reload full period");
  a_wake_default: assert property (woke && !in_hold
    |=> wdt_en_r && wdt_sel_r == WDT_SEL_MAX && !wdt_exc_mode_r)
    else $error("watchdog default lost on wake");
  a_thr_load: assert property (state_r == ST_BANDGAP && seq_done
    |=> svm_thr_o == $past(flash_thr_i))
    else $error("flash threshold not applied");
  a_svm_reset: assert property (svm_rst
    |=> state_r == ST_HOLD && cause_r[CAUSE_SVM_BIT])
    else $error("monitor reset lost");
  a_bod_hold: assert property (brownout_s |=> state_r == ST_HOLD)
    else $error("brownout did not hold reset");

endmodule
`default_nettype wire

// *** test/supply_pin_model.sv ***
// behavioural model of the external reset circuit and the supply rail
`timescale 1ns/100ps
`default_nettype none
module supply_pin_model #(
  parameter int BOD_FALL_MV = 1800   // brownout falling level, plain default
) (
  input  wire logic        pin_hold_i, // external circuit pulls the pin low
  input  wire logic [11:0] vdd_mv_i,   // rail level in millivolts
  input  wire logic [2:0]  thr_i,      // threshold code from the device
  output logic             pin_o,      // pin level at the device
  output logic             bod_o,      // high while rail under brownout level
  output logic             cmp_o       // high while rail above threshold
);
  logic [11:0] thr_mv;
  // eight threshold levels
  // hysteresis is analog and left out, so every crossing is sharp
  always_comb begin
    case (thr_i)
      3'h0: thr_mv = 12'h79E;
      3'h1: thr_mv = 12'h7D0;
      3'h2: thr_mv = 12'h834;
      3'h3: thr_mv = 12'h898;
      3'h4: thr_mv = 12'h8FC;
      3'h5: thr_mv = 12'h960;
      3'h6: thr_mv = 12'hA8C;
      default: thr_mv = 12'hBB8;
    endcase
  end
  // pin pulled up
  // the pull-up wins when released, so the last driven level never lingers
  assign pin_o = ~pin_hold_i;
  assign bod_o = (vdd_mv_i < 12'(BOD_FALL_MV));
  assign cmp_o = (vdd_mv_i > thr_mv);
endmodule
`default_nettype wire

// *** test/testbench.sv ***
// self-checking bench for the chip reset sequencer
`timescale 1ns/100ps
`default_nettype none
module testbench import rst_seq_pkg::*;;
  logic        clk, sys_rst, pin, bod, cmp, sleep, deep, stall, wr, rd;
  logic        pin_hold, rc_en, xtal_en, reg_en, cpu_rst, exc, irq;
  logic [2:0]  flash_thr, thr, svm_thr;
  logic [7:0]  addr;
  logic [11:0] vdd;
  logic [31:0] wdata, rdata;
  int          errors, n_tests, cycles;

  reset_sequencer #(.BANDGAP_CYCLES(20), .WDT_BASE_CYCLES(16)) reset_sequencer_inst (
    .clk_i(clk), .sys_rst_i(sys_rst), .external_reset_pin_low_i(pin),
    .brownout_detector_i(bod), .supply_level_monitor_i(cmp), .flash_thr_i(flash_thr),
    .sleep_i(sleep), .deep_sleep_i(deep), .dbg_stall_i(stall), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .rc_osc_en_o(rc_en),
    .xtal_en_o(xtal_en), .regulator_en_o(reg_en), .cpu_rst_o(cpu_rst),
    .svm_thr_o(svm_thr), .wdt_exc_o(exc), .irq_o(irq));
  supply_pin_model supply_pin_model_inst (
    .pin_hold_i(pin_hold), .vdd_mv_i(vdd), .thr_i(svm_thr), .pin_o(pin), .bod_o(bod),
    .cmp_o(cmp));

  // free-running 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // comparisons, one per kind of result
  task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic check_bit(input string name, input logic exp, input logic got);
    check_val(name, {31'h0, exp}, {31'h0, got});
  endtask
  task automatic check_rng(input string name, input int lo, input int hi, input int got);
    n_tests++;
    if (got < lo || got > hi) begin
      errors++;
      $display("unexpected %s expected %0d to %0d seen %0d", name, lo, hi, got);
    end
  endtask

  // register port: one-cycle strobes, read data the cycle after
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  // bounded wait on an output, n is the cycle count taken
  task automatic wait_for(input int sel, input int lim, output int n);
    logic hit = 1'b0;
    for (n = 1; n <= lim && !hit; n++) begin
      @(posedge clk);
      #1;
      case (sel)
        0: hit = (reg_en === 1'b1);
        1: hit = (cpu_rst === 1'b0);
        2: hit = (cpu_rst === 1'b1);
        3: hit = (exc === 1'b1);
        4: hit = (svm_thr === thr);
        5: hit = (rc_en === 1'b1);
        default: hit = (irq === 1'b1);
      endcase
    end
    n--;
    check_bit("wait_done", 1'b1, hit);
  endtask

  // one boot; slow keeps the rail low first and fails the first recheck
  task automatic boot(input logic [2:0] t, input logic slow);
    int n;
    flash_thr <= t;
    thr = t;
    if (slow) vdd <= 12'h76C;
    wait_for(5, 60, n);
    check_bit("xtal_en", 1'b1, xtal_en);
    if (slow) begin
      repeat (700) @(posedge clk);
      #1 check_bit("reg_en_low_vdd", 1'b0, reg_en);
      @(posedge clk);
      vdd <= 12'h9C4;
      wait_for(0, 8, n);
    end else begin
      wait_for(0, 700, n);
      check_rng("rc_wait", 640, 656, n);
    end
    wait_for(4, 800, n);
    check_rng("settle_bandgap", 767, 774, n);
    if (slow) begin
      repeat (300) @(posedge clk);
      #1 check_bit("recheck_hold", 1'b1, cpu_rst);
      @(posedge clk);
      vdd <= 12'hCE4;
      wait_for(1, 10, n);
    end else begin
      wait_for(1, 140, n);
      check_rng("thr_pause", 124, 132, n);
    end
  endtask

  task automatic reg_reset_test();
    logic [31:0] d;
    reg_rd(OFS_CAUSE, d);
    check_val("cause_por", 32'h01, d);
    reg_rd(OFS_WDT_CTRL, d);
    check_val("wdt_ctrl", 32'h17, d);
    reg_rd(OFS_SVM_CTRL, d);
    check_val("svm_on", 32'h18, d & 32'h18);
    reg_wr(8'h40, 32'hFFFFFFFF);
    reg_rd(OFS_INT_MASK, d);
    check_val("int_mask", 32'h0, d);
    reg_rd(8'h40, d);
    check_val("unmapped", 32'h0, d);
  endtask

  // kind 0 software, 1 pin, 2 brownout
  task automatic chip_reset(input int kind, input logic [31:0] cbit);
    logic [31:0] d;
    int n;
    reg_wr(OFS_CAUSE, 32'h1F);
    if (kind == 0) reg_wr(OFS_SYS_CTRL, 32'h1);
    else if (kind == 1) pin_hold <= 1'b1;
    else vdd <= 12'h5DC;
    wait_for(2, 8, n);
    if (kind != 0) begin
      repeat (300) @(posedge clk);
      #1 check_bit("hold_osc_off", 1'b0, rc_en);
      @(posedge clk);
      pin_hold <= 1'b0;
      vdd <= 12'hCE4;
    end
    reg_rd(OFS_CAUSE, d);
    check_val("cause", cbit, d & (kind == 2 ? 32'h1 : 32'h1F));
  endtask

  task automatic wdt_reset_test();
    logic [31:0] d;
    int n;
    reg_rd(OFS_WDT_CNT, d);
    check_bit("cnt_full", 1'b1, d > 32'h7F58 && d < 32'h8000);
    reg_wr(OFS_WDT_CTRL, 32'h5);
    reg_rd(OFS_WDT_CNT, d);
    check_bit("cnt_no_reload", 1'b1, d > 32'h7F58);
    repeat (4) begin
      reg_wr(OFS_WDT_KICK, 32'h0);
      repeat (50) @(posedge clk);
    end
    #1 check_bit("kicked_run", 1'b0, cpu_rst);
    reg_rd(OFS_WDT_CNT, d);
    check_bit("cnt_reload", 1'b1, d < 32'h40);
    reg_wr(OFS_CAUSE, 32'h1F);
    reg_wr(OFS_WDT_KICK, 32'h0);
    wait_for(2, 80, n);
    check_rng("wdt_period", 60, 70, n);
    reg_rd(OFS_CAUSE, d);
    check_val("cause_wdt", 32'h08, d);
  endtask

  task automatic wdt_exc_test();
    logic [31:0] d;
    int n;
    reg_wr(OFS_INT_MASK, 32'h4);
    reg_wr(OFS_WDT_CTRL, 32'h23);
    reg_wr(OFS_WDT_KICK, 32'h0);
    stall <= 1'b1;
    repeat (100) @(posedge clk);
    #1 check_bit("stall_quiet", 1'b0, irq);
    @(posedge clk);
    stall <= 1'b0;
    wait_for(3, 40, n);
    check_rng("exc_resume", 28, 36, n);
    check_bit("no_reset", 1'b0, cpu_rst);
    @(posedge clk);
    #1 check_bit("exc_pulse", 1'b0, exc);
    wait_for(6, 4, n);
    reg_wr(OFS_WDT_CTRL, 32'h22);
    reg_wr(OFS_INT_MASK, 32'h0);
    repeat (2) @(posedge clk);
    #1 check_bit("irq_masked", 1'b0, irq);
    reg_rd(OFS_INT_STAT, d);
    check_val("stat_wdt", 32'h4, d);
    reg_wr(OFS_INT_STAT, 32'h4);
    reg_rd(OFS_INT_STAT, d);
    check_val("stat_clear", 32'h0, d);
    // waking from either sleep restores the longest period; a shorter
    // enabled period before each sleep keeps the pause under watch
    reg_wr(OFS_WDT_CTRL, 32'h13);
    reg_wr(OFS_WDT_KICK, 32'h0);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      sleep <= (k == 0);
      deep <= (k == 1);
      repeat (50) @(posedge clk);
      sleep <= 1'b0;
      deep <= 1'b0;
      reg_rd(OFS_WDT_CTRL, d);
      check_val("wake_wdt", 32'h17, d & 32'h1F);
      reg_wr(OFS_WDT_CTRL, 32'h13);
    end
  endtask

  task automatic svm_test();
    logic [31:0] d;
    int n;
    for (int k = 0; k < 8; k++) begin
      reg_wr(OFS_SVM_CTRL, 32'h10 | 32'(k));
      repeat (2) @(posedge clk);
      #1 check_val("svm_thr", 32'(k), {29'h0, svm_thr});
    end
    reg_wr(OFS_INT_MASK, 32'h3);
    reg_wr(OFS_SVM_CTRL, 32'h11);
    vdd <= 12'h79E;
    wait_for(6, 8, n);
    reg_rd(OFS_INT_STAT, d);
    check_val("svm_fall", 32'h1, d);
    reg_wr(OFS_INT_STAT, 32'h3);
    repeat (3) @(posedge clk);
    vdd <= 12'hCE4;
    wait_for(6, 8, n);
    reg_rd(OFS_INT_STAT, d);
    check_val("svm_rise", 32'h2, d);
    reg_wr(OFS_CAUSE, 32'h1F);
    reg_wr(OFS_SVM_CTRL, 32'h19);
    vdd <= 12'h79E;
    wait_for(2, 8, n);
    reg_rd(OFS_CAUSE, d);
    check_val("cause_svm", 32'h10, d);
    vdd <= 12'hCE4;
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // hang guard, well above the expected run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      errors++;
      complete_run();
    end
  end

  // main sequence
  initial begin
    {sys_rst, vdd, flash_thr, pin_hold} = {1'b1, 12'hCE4, 3'h1, 1'b0};
    {sleep, deep, stall, wr, rd, addr, wdata} = '0;
    {errors, n_tests, cycles} = '0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    boot(3'h7, 1'b1);
    reg_reset_test();
    chip_reset(0, 32'h04);
    boot(3'h2, 1'b0);
    chip_reset(1, 32'h02);
    boot(3'h4, 1'b0);
    chip_reset(2, 32'h01);
    boot(3'h3, 1'b0);
    wdt_reset_test();
    boot(3'h5, 1'b0);
    wdt_exc_test();
    svm_test();
    boot(3'h6, 1'b0);
    complete_run();
  end
endmodule
`default_nettype wire
